//--- tivf_pkg.sv
// Constants, field layout and types shared by the temperature input formatter
package tivf_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_CH = 8;
	localparam int CH_W   = 3;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int CFG_W  = 8;
	localparam int MEAS_W = 18;
	localparam int ST_W   = 5;

	// ----------------------------------------------------------------
	// Register offsets (word addresses)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_CFG_BASE  = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_DATA_BASE = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_CLEAR     = 8'h11;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_EN    = 8'h12;
	localparam logic [ADDR_W-1:0] ADDR_READY     = 8'h13;

	// ----------------------------------------------------------------
	// Channel configuration fields and reset values
	// ----------------------------------------------------------------
	localparam int CFG_EN_BIT       = 0;
	localparam int CFG_RTD_BIT      = 1;
	localparam int CFG_TEMP_BIT     = 2;
	localparam int CFG_WIRE_LSB     = 3;
	localparam int CFG_OPEN_DET_BIT = 5;
	localparam int CFG_OVF_ALM_BIT  = 6;
	localparam int CFG_WB_ALM_BIT   = 7;
	localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Status / interrupt bits
	// ----------------------------------------------------------------
	localparam int ST_OVF_BIT   = 0;
	localparam int ST_UDF_BIT   = 1;
	localparam int ST_WB_BIT    = 2;
	localparam int ST_LOWV_BIT  = 3;
	localparam int ST_CALD_BIT  = 4;
	localparam logic [ST_W-1:0] ST_RESET = 5'h00;

	// ----------------------------------------------------------------
	// Data word codes and scaling
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] CODE_MARKER    = 16'h7fff;
	localparam logic [DATA_W-1:0] CODE_UNDERFLOW = 16'h8000;
	localparam int FULL_SCALE  = 27648;
	localparam int FS_SHIFT    = 14;
	localparam int TEMP_SCALE  = 10;
	localparam int TEMP_FRAC   = 4;
	localparam int OVF_LIMIT   = 32511;
	localparam int UDF_LIMIT   = -32512;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int CAL_TIME_US   = 1000;
	localparam int CAL_CYCLES    = CAL_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_CYCLES  = FLASH_HALF_MS * 1000000 / CLK_PERIOD_NS;
	localparam int CNT_W         = 27;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		WIRE_NONE  = 2'b00,
		WIRE_TWO   = 2'b01,
		WIRE_THREE = 2'b10,
		WIRE_FOUR  = 2'b11
	} tivf_wire_type;

	typedef enum logic {
		CAL_RUN  = 1'b0,
		CAL_DONE = 1'b1
	} tivf_cal_type;

endpackage : tivf_pkg

//--- tivf_word_mem.sv
// Channel data word store with registered read data
module tivf_word_mem
	import tivf_pkg::*;
(
	// Clock
	input  wire logic              clk,
	// Write port
	input  wire logic              wr_en,
	input  wire logic [CH_W-1:0]   wr_addr,
	input  wire logic [DATA_W-1:0] wr_data,
	// Read port
	input  wire logic              rd_en,
	input  wire logic [CH_W-1:0]   rd_addr,
	output logic      [DATA_W-1:0] rd_data
);

	logic [DATA_W-1:0] mem_r [NUM_CH];

	always_ff @(posedge clk)
	begin
		if (wr_en)
			mem_r[wr_addr] <= wr_data;
	end

	always_ff @(posedge clk)
	begin
		if (rd_en)
			rd_data <= mem_r[rd_addr];
	end

endmodule : tivf_word_mem

//--- tivf_scaler.sv
// Converts one raw measurement into a saturated signed data word
module tivf_scaler
	import tivf_pkg::*;
(
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	// Raw measurement in
	input  wire logic                     in_valid,
	input  wire logic [CH_W-1:0]          in_chan,
	input  wire logic signed [MEAS_W-1:0] in_meas,
	input  wire logic signed [MEAS_W-1:0] in_lead,
	input  wire logic                     in_rtd,
	input  wire logic                     in_temp,
	input  wire logic [1:0]               in_wires,
	// Formatted result out
	output logic                          out_valid,
	output logic [CH_W-1:0]               out_chan,
	output logic [DATA_W-1:0]             out_data,
	output logic                          out_ovf,
	output logic                          out_udf
);

	logic signed [MEAS_W:0] corr;
	logic signed [35:0]     val;
	logic                   res_range;

	always_comb
	begin
		// Three-wire RTD subtracts the lead drop; all other settings use meas
		if (tivf_wire_type'(in_wires) == WIRE_THREE && in_rtd)
			corr = (MEAS_W+1)'(in_meas) - (MEAS_W+1)'(in_lead);
		else
			corr = (MEAS_W+1)'(in_meas);
		if (in_temp)
			val = (36'(corr) * 36'(TEMP_SCALE)) >>> TEMP_FRAC;
		else
			val = (36'(corr) * 36'(FULL_SCALE)) >>> FS_SHIFT;
	end

	assign res_range = in_rtd && !in_temp;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			out_valid <= 1'b0;
			out_chan  <= '0;
			out_data  <= '0;
			out_ovf   <= 1'b0;
			out_udf   <= 1'b0;
		end
		else
		begin
			out_valid <= in_valid;
			out_chan  <= in_chan;
			out_ovf   <= 1'b0;
			out_udf   <= 1'b0;
			if (val > 36'(OVF_LIMIT))
			begin
				out_data <= CODE_MARKER;
				out_ovf  <= 1'b1;
			end
			else if (val < 36'(UDF_LIMIT))
			begin
				// Resistance ranges clamp silently, never underflow
				if (res_range)
					out_data <= DATA_W'(UDF_LIMIT);
				else
				begin
					out_data <= CODE_UNDERFLOW;
					out_udf  <= 1'b1;
				end
			end
			else
				out_data <= val[DATA_W-1:0];
		end
	end

endmodule : tivf_scaler

//--- tivf_formatter.sv
// Temperature input channel group: formatting, markers and diagnostics
//
// Implementation choices: the strobed register port and the address map.
module tivf_formatter
	import tivf_pkg::*;
#(
	parameter int CAL_CYCLES_P   = CAL_CYCLES,
	parameter int FLASH_CYCLES_P = FLASH_CYCLES,
	parameter bit MULTI_CH       = 1'b1
)
(
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	// Register port
	input  wire logic [tivf_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [tivf_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [tivf_pkg::DATA_W-1:0] reg_rdata,
	// Conversion results from the converter sequencer
	input  wire logic                     conv_valid,
	input  wire logic [tivf_pkg::CH_W-1:0] conv_chan,
	input  wire logic signed [tivf_pkg::MEAS_W-1:0] conv_meas,
	input  wire logic signed [tivf_pkg::MEAS_W-1:0] conv_lead,
	input  wire logic                     conv_no_sensor,
	input  wire logic                     conv_open_wire,
	// Supply monitor
	input  wire logic                     supply_low,
	// Indicators and interrupt
	output logic      [tivf_pkg::NUM_CH-1:0] fault_led,
	output logic                          irq
);

	// ----------------------------------------------------------------
	// Address decoding
	// ----------------------------------------------------------------
	function automatic logic in_bank(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] base);
		in_bank = (a[ADDR_W-1:CH_W] == base[ADDR_W-1:CH_W]);
	endfunction : in_bank

	logic [CFG_W-1:0]  cfg_r [NUM_CH];
	logic [ST_W-1:0]   status_r;
	logic [ST_W-1:0]   irq_en_r;
	logic [NUM_CH-1:0] ready_r;
	logic [NUM_CH-1:0] no_sensor_r;
	logic              rd_mem_r;
	logic              rd_ready_r;
	logic [DATA_W-1:0] rd_reg_r;
	logic [DATA_W-1:0] mem_q;
	logic [CH_W-1:0]   idx;

	assign idx = reg_addr[CH_W-1:0];

	// ----------------------------------------------------------------
	// Channel configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < NUM_CH; i++)
				cfg_r[i] <= CFG_RESET;
		end
		else if (reg_wr && in_bank(reg_addr, ADDR_CFG_BASE))
			cfg_r[idx] <= reg_wdata[CFG_W-1:0];
	end

	// ----------------------------------------------------------------
	// Power-up calibration
	// ----------------------------------------------------------------
	tivf_cal_type       cal_state_r;
	tivf_cal_type       cal_state_nxt;
	logic [CNT_W-1:0]   cal_cnt_r;
	logic               cal_end;

	assign cal_end = (cal_cnt_r == CNT_W'(CAL_CYCLES_P - 1));

	always_comb
	begin
		case (cal_state_r)
			CAL_RUN:  cal_state_nxt = cal_end ? CAL_DONE : CAL_RUN;
			CAL_DONE: cal_state_nxt = CAL_DONE;
			default:  cal_state_nxt = CAL_RUN;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cal_state_r <= CAL_RUN;
			cal_cnt_r   <= '0;
		end
		else
		begin
			cal_state_r <= cal_state_nxt;
			if (cal_state_r == CAL_RUN)
				cal_cnt_r <= cal_cnt_r + CNT_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// Conversion path
	// ----------------------------------------------------------------
	logic [CFG_W-1:0]  conv_cfg;
	logic              conv_take;
	logic              sc_valid;
	logic [CH_W-1:0]   sc_chan;
	logic [DATA_W-1:0] sc_data;
	logic              sc_ovf;
	logic              sc_udf;
	logic              sc_nosens_r;
	logic              sc_open_r;
	logic              wr_en;
	logic [DATA_W-1:0] wr_data;

	assign conv_cfg  = cfg_r[conv_chan];
	// Results during calibration are discarded
	assign conv_take = conv_valid && conv_cfg[CFG_EN_BIT]
		&& (cal_state_r == CAL_DONE);

	tivf_scaler u_scaler (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (conv_take),
		.in_chan   (conv_chan),
		.in_meas   (conv_meas),
		.in_lead   (conv_lead),
		.in_rtd    (conv_cfg[CFG_RTD_BIT]),
		.in_temp   (conv_cfg[CFG_TEMP_BIT]),
		.in_wires  (conv_cfg[CFG_WIRE_LSB +: 2]),
		.out_valid (sc_valid),
		.out_chan  (sc_chan),
		.out_data  (sc_data),
		.out_ovf   (sc_ovf),
		.out_udf   (sc_udf)
	);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sc_nosens_r <= 1'b0;
			sc_open_r   <= 1'b0;
		end
		else
		begin
			sc_nosens_r <= conv_no_sensor;
			sc_open_r   <= conv_open_wire;
		end
	end

	// Marker substitution ahead of the store
	always_comb
	begin
		wr_en   = sc_valid;
		wr_data = sc_data;
		if (sc_nosens_r)
			wr_data = CODE_MARKER;
		else if (MULTI_CH && supply_low)
			wr_data = CODE_MARKER;
	end

	tivf_word_mem u_mem (
		.clk     (clk),
		.wr_en   (wr_en),
		.wr_addr (sc_chan),
		.wr_data (wr_data),
		.rd_en   (reg_rd),
		.rd_addr (idx),
		.rd_data (mem_q)
	);

	// Per-channel data availability and sensor presence
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ready_r     <= '0;
			no_sensor_r <= '0;
		end
		else if (wr_en)
		begin
			ready_r[sc_chan]     <= 1'b1;
			no_sensor_r[sc_chan] <= sc_nosens_r;
		end
	end

	// ----------------------------------------------------------------
	// Fault indicators
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] flash_cnt_r;
	logic             flash_r;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			flash_cnt_r <= '0;
			flash_r     <= 1'b0;
		end
		else if (flash_cnt_r == CNT_W'(FLASH_CYCLES_P - 1))
		begin
			flash_cnt_r <= '0;
			flash_r     <= ~flash_r;
		end
		else
			flash_cnt_r <= flash_cnt_r + CNT_W'(1);
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_led
			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
					fault_led[g] <= 1'b0;
				else
					fault_led[g] <= flash_r && no_sensor_r[g]
						&& cfg_r[g][CFG_EN_BIT]
						&& cfg_r[g][CFG_OPEN_DET_BIT];
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Diagnostic status and interrupt
	// ----------------------------------------------------------------
	logic [CFG_W-1:0] sc_cfg;
	logic [ST_W-1:0]  st_set;
	logic [ST_W-1:0]  st_clr;

	assign sc_cfg = cfg_r[sc_chan];

	always_comb
	begin
		st_set = '0;
		st_set[ST_OVF_BIT]  = sc_valid && sc_ovf && sc_cfg[CFG_OVF_ALM_BIT];
		st_set[ST_UDF_BIT]  = sc_valid && sc_udf && sc_cfg[CFG_OVF_ALM_BIT];
		st_set[ST_WB_BIT]   = sc_valid && sc_open_r
			&& sc_cfg[CFG_WB_ALM_BIT];
		st_set[ST_LOWV_BIT] = MULTI_CH && supply_low;
		st_set[ST_CALD_BIT] = (cal_state_r == CAL_RUN) && cal_end;
		st_clr = (reg_wr && reg_addr == ADDR_CLEAR) ?
			reg_wdata[ST_W-1:0] : '0;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			status_r <= ST_RESET;
		else
			status_r <= (status_r & ~st_clr) | st_set;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			irq_en_r <= ST_RESET;
		else if (reg_wr && reg_addr == ADDR_IRQ_EN)
			irq_en_r <= reg_wdata[ST_W-1:0];
	end

	assign irq = |(status_r & irq_en_r);

	// ----------------------------------------------------------------
	// Register read path
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_mem_r   <= 1'b0;
			rd_ready_r <= 1'b0;
			rd_reg_r   <= '0;
		end
		else if (reg_rd)
		begin
			rd_mem_r   <= in_bank(reg_addr, ADDR_DATA_BASE);
			rd_ready_r <= ready_r[idx];
			rd_reg_r   <= '0;
			if (in_bank(reg_addr, ADDR_CFG_BASE))
				rd_reg_r <= DATA_W'(cfg_r[idx]);
			else if (reg_addr == ADDR_STATUS)
				rd_reg_r <= DATA_W'(status_r);
			else if (reg_addr == ADDR_IRQ_EN)
				rd_reg_r <= DATA_W'(irq_en_r);
			else if (reg_addr == ADDR_READY)
				rd_reg_r <= DATA_W'(ready_r);
		end
	end

	// Channels without a valid result read the marker
	assign reg_rdata = !rd_mem_r ? rd_reg_r :
		(rd_ready_r ? mem_q : CODE_MARKER);

endmodule : tivf_formatter

//--- tivf_formatter_asserts.sv
// Port assertions for the temperature input formatter
module tivf_formatter_asserts
	import tivf_pkg::*;
#(
	parameter int CAL_CYCLES_P   = CAL_CYCLES,
	parameter int FLASH_CYCLES_P = FLASH_CYCLES,
	parameter bit MULTI_CH       = 1'b1
)
(
	// Clock and reset
	input wire logic                     clk,
	input wire logic                     rst_b,
	// Register port
	input wire logic [ADDR_W-1:0]        reg_addr,
	input wire logic [DATA_W-1:0]        reg_wdata,
	input wire logic                     reg_wr,
	input wire logic                     reg_rd,
	input wire logic [DATA_W-1:0]        reg_rdata,
	// Conversion stream and supply
	input wire logic                     conv_valid,
	input wire logic [CH_W-1:0]          conv_chan,
	input wire logic signed [MEAS_W-1:0] conv_meas,
	input wire logic signed [MEAS_W-1:0] conv_lead,
	input wire logic                     conv_no_sensor,
	input wire logic                     conv_open_wire,
	input wire logic                     supply_low,
	// Indicators
	input wire logic [NUM_CH-1:0]        fault_led,
	input wire logic                     irq
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----
	// Shadow of configuration and calibration time
	// ----
	localparam int LED_MAX = FLASH_CYCLES_P + 3;
	logic [CFG_W-1:0]         cfg_r [NUM_CH];
	logic [CFG_W-1:0]         cc;
	logic [26:0]              cal_cnt_r;
	logic                     cal_done, cal_run, plain, quiet;
	logic signed [MEAS_W-1:0] eff;
	assign cal_done = cal_cnt_r >= 27'(CAL_CYCLES_P + 2);
	assign cal_run = cal_cnt_r < 27'(CAL_CYCLES_P - 2);
	assign cc = cfg_r[conv_chan];
	assign plain = !conv_no_sensor && !conv_open_wire && !supply_low;
	assign quiet = !conv_valid && !supply_low;
	// Three-wire resistance (RTD) sensors subtract the lead drop
	assign eff = (cc[CFG_RTD_BIT] && cc[CFG_WIRE_LSB+:2] == WIRE_THREE)
		? conv_meas - conv_lead : conv_meas;
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			cal_cnt_r <= '0;
		else if (!cal_done)
			cal_cnt_r <= cal_cnt_r + 27'h1;
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			cfg_r <= '{default: CFG_RESET};
		else if (reg_wr && reg_addr < ADDR_DATA_BASE)
			cfg_r[reg_addr[CH_W-1:0]] <= reg_wdata[CFG_W-1:0];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Accepted conversion, quiet gap, then read of its data word
	sequence conv_rd_s(c, m);
		conv_valid && cal_done && cc[CFG_EN_BIT] && c ##1 m[*2]
		##1 reg_rd && reg_addr == ADDR_DATA_BASE + 8'($past(conv_chan, 3));
	endsequence
	// ----
	// Assertions
	// ----
	no_sensor_a:
	assert property (conv_rd_s(conv_no_sensor, !conv_valid)
		|=> reg_rdata == CODE_MARKER) else $error("no sensor word wrong");
	scale_word_a:
	assert property (conv_rd_s(plain && !cc[CFG_TEMP_BIT] &&
		eff < 18'sh0_4001 && eff > 18'sh3_bfff, quiet) |=> reg_rdata ==
		16'((35'($past(eff, 4)) * 35'sh0_6c00) >>> 14))
		else $error("scaled word wrong");
	temp_tenths_a:
	assert property (conv_rd_s(plain && cc[CFG_TEMP_BIT] &&
		eff < 18'sh0_0bb8 && eff > 18'sh3_f448, quiet) |=> reg_rdata ==
		16'((24'($past(eff, 4)) * 24'sh00_000a) >>> 4))
		else $error("temperature word wrong");
	ovf_code_a:
	assert property (conv_rd_s(plain && !cc[CFG_TEMP_BIT] &&
		eff > 18'sh0_4b42, quiet) |=> reg_rdata == CODE_MARKER)
		else $error("overflow code missing");
	udf_code_a:
	assert property (conv_rd_s(plain && !cc[CFG_TEMP_BIT] &&
		!cc[CFG_RTD_BIT] && eff < 18'sh3_b4be, quiet)
		|=> reg_rdata == CODE_UNDERFLOW) else $error("underflow code missing");
	rtd_no_udf_a:
	assert property (conv_rd_s(plain && !cc[CFG_TEMP_BIT] &&
		cc[CFG_RTD_BIT] && eff < 18'sh3_b4be, quiet)
		|=> reg_rdata == 16'h8100) else $error("resistance underflow flagged");
	supply_mark_a:
	assert property (conv_rd_s(MULTI_CH && supply_low, !conv_valid &&
		supply_low) |=> reg_rdata == CODE_MARKER) else $error("low supply");
	cal_marker_a:
	assert property (cal_run && reg_rd && reg_addr >= ADDR_DATA_BASE &&
		reg_addr < ADDR_STATUS |=> reg_rdata == CODE_MARKER)
		else $error("calibration marker missing");
	led_flash_a:
	assert property (fault_led != '0 |-> ##[1:LED_MAX] fault_led == '0)
		else $error("fault indicator not flashing");
endmodule : tivf_formatter_asserts

bind tivf_formatter tivf_formatter_asserts #(
	.CAL_CYCLES_P(CAL_CYCLES_P), .FLASH_CYCLES_P(FLASH_CYCLES_P),
	.MULTI_CH(MULTI_CH)) u_chk (.clk, .rst_b, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .conv_valid, .conv_chan, .conv_meas,
	.conv_lead, .conv_no_sensor, .conv_open_wire, .supply_low,
	.fault_led, .irq);

//--- tivf_host_model.sv
// Host processor model: master of the register port
module tivf_host_model
	import tivf_pkg::*;
(
	// Clock
	input wire logic         clk,
	// Register port
	output logic [ADDR_W-1:0] reg_addr,
	output logic [DATA_W-1:0] reg_wdata,
	output logic              reg_wr,
	output logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// ----
	// Bus cycles; idle lines show the inverse of the last value
	// ----
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~v;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 v = reg_rdata;
	endtask : rd
	// Data words are not trusted before calibration has finished
	task automatic wait_cal(output bit ok);
		logic [DATA_W-1:0] s;
		ok = 1'b0;
		for (int i = 0; i < 200 && !ok; i++)
			begin
			rd(ADDR_STATUS, s);
			ok = s[ST_CALD_BIT] === 1'b1;
			end
	endtask : wait_cal
endmodule : tivf_host_model

//--- test_tivf_formatter.sv
// Self-checking bench for the temperature input formatter
module test_tivf_formatter
	import tivf_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic                clk, rst_b, conv_valid, conv_no_sensor;
	logic                conv_open_wire, supply_low, reg_wr, reg_rd, irq;
	logic [CH_W-1:0]     conv_chan;
	logic [MEAS_W-1:0]   conv_meas, conv_lead;
	logic [ADDR_W-1:0]   reg_addr;
	logic [DATA_W-1:0]   reg_wdata, reg_rdata, d;
	logic [NUM_CH-1:0]   fault_led;
	int                  n_fail, samples_checked;
	bit                  ok;
	tivf_host_model host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata);
	tivf_formatter #(.CAL_CYCLES_P(40), .FLASH_CYCLES_P(4)) uut (.clk,
		.rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.conv_valid, .conv_chan, .conv_meas, .conv_lead, .conv_no_sensor,
		.conv_open_wire, .supply_low, .fault_led, .irq);
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ----
	// Shared tasks
	// ----
	task automatic check_word(input logic [DATA_W-1:0] got, want);
		samples_checked++;
		if (got !== want)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask : check_word
	task automatic conv(input logic [CH_W-1:0] c,
		input logic [MEAS_W-1:0] m, l, input logic ns);
		@(posedge clk);
		conv_valid <= 1'b1;
		conv_chan <= c;
		conv_meas <= m;
		conv_lead <= l;
		conv_no_sensor <= ns;
		@(posedge clk);
		conv_valid <= 1'b0;
	endtask : conv
	task automatic run_case(input logic [CH_W-1:0] ch,
		input logic [CFG_W-1:0] cf, input logic [MEAS_W-1:0] m, l,
		input logic [DATA_W-1:0] want);
		host.wr(8'(ch), 16'(cf));
		conv(ch, m, l, 1'b0);
		@(posedge clk);
		host.rd(ADDR_DATA_BASE + 8'(ch), d);
		check_word(d, want);
	endtask : run_case
	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	// ----
	// Scenarios
	// ----
	task automatic t_cal;
		host.wr(ADDR_CFG_BASE, 16'h0001);
		conv(3'h0, 18'h0_4000, 18'h0_0000, 1'b0);
		host.rd(ADDR_DATA_BASE, d);
		check_word(d, CODE_MARKER);
		host.rd(ADDR_CFG_BASE + 8'h01, d);
		check_word(d, 16'h0000);
		host.rd(8'h20, d);
		check_word(d, 16'h0000);
		host.wait_cal(ok);
		check_word(16'(ok), 16'h0001);
		if (!ok)
			report_and_stop;
		host.rd(ADDR_DATA_BASE, d);
		check_word(d, CODE_MARKER);
		host.rd(ADDR_READY, d);
		check_word(d, 16'h0000);
		$display("calibration test done");
	endtask : t_cal
	task automatic t_formats;
		run_case(3'h0, 8'h01, 18'h0_4000, 18'h0_0000, 16'h6c00);
		run_case(3'h1, 8'h0b, 18'h0_4000, 18'h0_0064, 16'h6c00);
		run_case(3'h2, 8'h13, 18'h0_4064, 18'h0_0064, 16'h6c00);
		run_case(3'h3, 8'h1b, 18'h0_4000, 18'h0_0064, 16'h6c00);
		run_case(3'h4, 8'h05, 18'h0_0195, 18'h0_0000, 16'h00fd);
		run_case(3'h5, 8'h1f, 18'h3_ff60, 18'h0_0000, 16'hff9c);
		run_case(3'h6, 8'h01, 18'h0_4b43, 18'h0_0000, CODE_MARKER);
		run_case(3'h7, 8'h01, 18'h3_b4bd, 18'h0_0000, 16'h8000);
		run_case(3'h6, 8'h01, 18'h0_4b42, 18'h0_0000, 16'h7eff);
		run_case(3'h7, 8'h01, 18'h3_b4be, 18'h0_0000, 16'h8100);
		run_case(3'h0, 8'h1b, 18'h3_b1e0, 18'h0_0000, 16'h8100);
		$display("format test done");
	endtask : t_formats
	task automatic t_status_irq;
		host.wr(ADDR_CLEAR, 16'h000f);
		host.wr(ADDR_IRQ_EN, 16'h0001);
		host.rd(ADDR_IRQ_EN, d);
		check_word(d, 16'h0001);
		run_case(3'h1, 8'h41, 18'h0_4b43, 18'h0_0000, CODE_MARKER);
		host.rd(ADDR_STATUS, d);
		check_word(d, 16'h0011);
		check_word(16'(irq), 16'h0001);
		host.wr(ADDR_CLEAR, 16'h0001);
		#1 check_word(16'(irq), 16'h0000);
		host.wr(ADDR_IRQ_EN, 16'h0000);
		run_case(3'h1, 8'h41, 18'h0_4b43, 18'h0_0000, CODE_MARKER);
		check_word(16'(irq), 16'h0000);
		// Open wire with its alarm on, underflow with its alarm on
		@(posedge clk);
		conv_open_wire <= 1'b1;
		run_case(3'h2, 8'hc1, 18'h3_b4bd, 18'h0_0000, 16'h8000);
		@(posedge clk);
		conv_open_wire <= 1'b0;
		host.rd(ADDR_STATUS, d);
		check_word(d, 16'h0017);
		host.rd(ADDR_READY, d);
		check_word(d, 16'h00ff);
		$display("status test done");
	endtask : t_status_irq
	task automatic t_no_sensor;
		int hi2, hi3;
		hi2 = 0;
		hi3 = 0;
		host.wr(ADDR_CFG_BASE + 8'h02, 16'h0021);
		host.wr(ADDR_CFG_BASE + 8'h03, 16'h0001);
		@(posedge clk);
		conv_valid <= 1'b1;
		conv_chan <= 3'h3;
		conv_meas <= 18'h0_4000;
		@(posedge clk);
		conv_chan <= 3'h2;
		conv_no_sensor <= 1'b1;
		@(posedge clk);
		conv_valid <= 1'b0;
		conv_no_sensor <= 1'b0;
		@(posedge clk);
		host.rd(ADDR_DATA_BASE + 8'h02, d);
		check_word(d, CODE_MARKER);
		host.rd(ADDR_DATA_BASE + 8'h03, d);
		check_word(d, 16'h6c00);
		repeat (20)
		begin
			@(negedge clk);
			if (fault_led[2] === 1'b1)
				hi2++;
			if (fault_led[3] !== 1'b0)
				hi3++;
		end
		check_word(16'(hi2 > 0 && hi2 < 20), 16'h0001);
		check_word(16'(hi3), 16'h0000);
		$display("no sensor test done");
	endtask : t_no_sensor
	task automatic t_supply;
		@(posedge clk);
		supply_low <= 1'b1;
		run_case(3'h4, 8'h01, 18'h0_4000, 18'h0_0000, CODE_MARKER);
		@(posedge clk);
		supply_low <= 1'b0;
		host.rd(ADDR_STATUS, d);
		check_word(16'(d[ST_LOWV_BIT]), 16'h0001);
		$display("supply test done");
	endtask : t_supply
	initial
	begin
		rst_b = 1'b0;
		conv_valid = 1'b0;
		conv_chan = '0;
		conv_meas = '0;
		conv_lead = '0;
		conv_no_sensor = 1'b0;
		conv_open_wire = 1'b0;
		supply_low = 1'b0;
		n_fail = 0;
		samples_checked = 0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		t_cal;
		t_formats;
		t_status_irq;
		t_no_sensor;
		t_supply;
		report_and_stop;
	end
endmodule : test_tivf_formatter
